/* core/link_failover_controller.sv */
// Failover controller that keeps one link of a redundant pair active.
//
// Notes on behaviour
// - Reset: both ports disabled, secondary on standby.
// - Enable primary at start only when healthy.
// - Failover drops primary first, then enables secondary.
// - Switchover takes 3 to 10 ms.
// - Repaired primary waits for secondary trouble.
// - Primary and secondary designations never change.
// - Never both links active at once.
// - Link states tracked and reported outward.
// - Every link state transition counted.
// - Partial mode: receive loss or partition fails over.
// - Partial mode: collision, jabber, attachment faults too.
// - Transmit path faults undetectable with nonresponders.
// - Full mode: responder indication swaps the active port.
// - Full mode detects transmit and receive faults.
`timescale 1ns/10ps
`default_nettype none

module link_failover_controller #(
    parameter int unsigned SWITCH_CYCLES = failover_pkg::SWITCH_MIN_CYCLES // Gap, cycles.
) (
    input wire logic CORE_CLK, // Core clock, 10 MHz.
    input wire logic ARST_N, // Asynchronous reset, active low.
    input wire logic FULL_DETECT, // High when the far ends are responders.
    input wire logic PRI_RX_LOSS, // Primary receive link lost.
    input wire logic PRI_PARTITION, // Primary port partitioned.
    input wire logic PRI_EXC_COLL, // Primary excessive collisions.
    input wire logic PRI_LONG_COLL, // Primary over-long collision.
    input wire logic PRI_JABBER, // Primary received jabber.
    input wire logic PRI_MAU_FAIL, // Primary attachment unit failure.
    input wire logic PRI_RESP_FAIL, // Responder on primary link reports loss.
    input wire logic SEC_RX_LOSS, // Secondary receive link lost.
    input wire logic SEC_PARTITION, // Secondary port partitioned.
    input wire logic SEC_EXC_COLL, // Secondary excessive collisions.
    input wire logic SEC_LONG_COLL, // Secondary over-long collision.
    input wire logic SEC_JABBER, // Secondary received jabber.
    input wire logic SEC_MAU_FAIL, // Secondary attachment unit failure.
    input wire logic SEC_RESP_FAIL, // Responder on secondary link reports loss.
    input wire logic SEC_DISABLED, // Secondary port disabled internally.
    output logic PRI_ENABLE, // Primary master port enabled.
    output logic SEC_ENABLE, // Secondary master port enabled.
    output logic SEC_IN_USE, // High from the primary drop until the secondary is dropped.
    output logic PRI_LINK_UP, // Primary link seen healthy.
    output logic SEC_LINK_UP, // Secondary link seen healthy.
    output logic [failover_pkg::COUNT_W-1:0] XFER_COUNT // Link state transitions.
);
    import failover_pkg::*;

    // ==========================================================
    // Input synchronisers
    // ==========================================================
    // Raw pin vector: mode, secondary disable, then both fault vectors.
    logic [2*FLT_W+1:0] raw_in;
    // First synchroniser stage, read only by the second stage.
    logic [2*FLT_W+1:0] sync_meta;
    // Second synchroniser stage, safe for logic.
    logic [2*FLT_W+1:0] sync_in;
    // Synchronised primary and secondary fault vectors.
    logic [FLT_W-1:0] pri_flt;
    logic [FLT_W-1:0] sec_flt;
    // Synchronised mode and secondary disable.
    logic full_mode;
    logic sec_off;

    assign raw_in = {FULL_DETECT, SEC_DISABLED,
                     SEC_RESP_FAIL, SEC_MAU_FAIL, SEC_JABBER, SEC_LONG_COLL,
                     SEC_EXC_COLL, SEC_PARTITION, SEC_RX_LOSS,
                     PRI_RESP_FAIL, PRI_MAU_FAIL, PRI_JABBER, PRI_LONG_COLL,
                     PRI_EXC_COLL, PRI_PARTITION, PRI_RX_LOSS};

    // Every pin comes from another domain, so it passes two flops first.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            // Both stages reset to every fault present. A cleared stage would
            // read as a healthy primary and enable it for two cycles before
            // the real pin levels arrive, even with the primary broken.
            sync_meta <= '1;
            sync_in <= '1;
        end else begin
            sync_meta <= raw_in;
            sync_in <= sync_meta;
        end
    end

    assign pri_flt = sync_in[FLT_W-1:0];
    assign sec_flt = sync_in[2*FLT_W-1:FLT_W];
    assign sec_off = sync_in[2*FLT_W];
    assign full_mode = sync_in[2*FLT_W+1];

    // ==========================================================
    // Fault decode
    // ==========================================================
    // Folds one link's fault vector into a failure decision.
    // A responder indication only counts in full mode: a nonresponder
    // leaves the pin idle, and its transmit path faults stay unseen.
    function automatic logic link_failed(input logic [FLT_W-1:0] flt, input logic full);
        link_failed = flt[FLT_RX_LOSS] | flt[FLT_PARTITION]
                    | flt[FLT_EXC_COLL] | flt[FLT_LONG_COLL]
                    | flt[FLT_JABBER] | flt[FLT_MAU]
                    | (full & flt[FLT_RESPONDER]);
    endfunction : link_failed

    // Failure decisions for each link.
    logic pri_fail;
    logic sec_fail;
    // Reasons to leave the secondary and return to the primary.
    logic back_evt;

    assign pri_fail = link_failed(pri_flt, full_mode);
    assign sec_fail = link_failed(sec_flt, full_mode);
    // A partitioned secondary is already in sec_fail; a disable adds to it.
    assign back_evt = sec_fail | sec_off;

    // ==========================================================
    // Active-link state machine
    // ==========================================================
    // Current and next controller state.
    link_state_t state;
    link_state_t next_state;
    // Gap timer between dropping one port and enabling the other.
    logic [TIMER_W-1:0] timer;
    logic [TIMER_W-1:0] next_timer;
    // Next values of the registered port enables and in-use flag.
    logic next_pri_en;
    logic next_sec_en;
    logic next_sec_use;
    // Transition counter.
    logic [COUNT_W-1:0] count;
    logic [COUNT_W-1:0] next_count;

    // Timer load for the gap, one less than its length in cycles, in timer width; the parameter is narrowed on purpose.
    localparam logic [TIMER_W-1:0] GAP = TIMER_W'(SWITCH_CYCLES - 1);

    // Next-state logic. Each decision moves the machine out of the state
    // that saw the cause, so one fault produces exactly one switchover.
    // A broken primary may be returned to when the secondary fails too;
    // the bounded gap keeps such a ping-pong slow and never overlaps ports.
    always_comb begin
        next_state = state;
        next_timer = timer;
        unique case (state)
            // Hold everything off until the primary looks healthy.
            ST_INIT: begin
                if (!pri_fail) begin
                    next_state = ST_PRI_ACTIVE;
                end
            end
            // Primary carries traffic; any fault starts the switchover.
            ST_PRI_ACTIVE: begin
                if (pri_fail) begin
                    next_state = ST_TO_SEC;
                    next_timer = GAP;
                end
            end
            // Primary is already off; count out the gap, then secondary.
            ST_TO_SEC: begin
                if (timer == '0) begin
                    next_state = ST_SEC_ACTIVE;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            // A repaired primary is ignored; only secondary trouble counts.
            ST_SEC_ACTIVE: begin
                if (back_evt) begin
                    next_state = ST_TO_PRI;
                    next_timer = GAP;
                end
            end
            // Secondary is off; count out the gap, then primary again.
            ST_TO_PRI: begin
                if (timer == '0) begin
                    next_state = ST_PRI_ACTIVE;
                end else begin
                    next_timer = timer - 1'b1;
                end
            end
            default: begin
                next_state = ST_INIT;
            end
        endcase
    end

    // Output and counter next values, taken from the next state so the
    // enables change together with the state they belong to.
    always_comb begin
        next_pri_en = (next_state == ST_PRI_ACTIVE);
        next_sec_en = (next_state == ST_SEC_ACTIVE);
        next_sec_use = next_sec_en | (next_state == ST_TO_SEC);
        next_count = count;
        if (next_state != state) begin
            next_count = count + 1'b1;
        end
    end

    // State registers. The counter wraps; management reads differences.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            state <= ST_INIT;
            timer <= TIMER_RESET;
            PRI_ENABLE <= 1'b0;
            SEC_ENABLE <= 1'b0;
            SEC_IN_USE <= 1'b0;
            count <= COUNT_RESET;
        end else begin
            state <= next_state;
            timer <= next_timer;
            PRI_ENABLE <= next_pri_en;
            SEC_ENABLE <= next_sec_en;
            SEC_IN_USE <= next_sec_use;
            count <= next_count;
        end
    end

    // ==========================================================
    // Link status
    // ==========================================================
    // Health of each link, registered for management.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            PRI_LINK_UP <= 1'b0;
            SEC_LINK_UP <= 1'b0;
        end else begin
            PRI_LINK_UP <= !pri_fail;
            SEC_LINK_UP <= !(sec_fail | sec_off);
        end
    end

    assign XFER_COUNT = count;

    // ==========================================================
    // Checks
    // ==========================================================
    // Cycles both ports have been off, for timing checks.
    logic [TIMER_W-1:0] off_cnt;
    localparam logic [TIMER_W-1:0] MIN_OFF = TIMER_W'(SWITCH_MIN_CYCLES);
    localparam logic [TIMER_W-1:0] MAX_OFF = TIMER_W'(SWITCH_MAX_CYCLES);

    // Helper counter read only by assertions.
    always_ff @(posedge CORE_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            off_cnt <= TIMER_RESET;
        end else if (PRI_ENABLE || SEC_ENABLE) begin
            off_cnt <= TIMER_RESET;
        end else if (off_cnt != '1) begin
            off_cnt <= off_cnt + 1'b1;
        end
    end

    never_both_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        !(PRI_ENABLE && SEC_ENABLE))
        else $error("Both ports enabled together.");

    drop_first_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(SEC_ENABLE) |-> !$past(PRI_ENABLE) && $past(SEC_IN_USE))
        else $error("Secondary enabled before primary was dropped.");

    // At the edge that sees the secondary rise, the helper still holds the
    // full count of cycles for which both ports were off; it clears later.
    switch_time_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        $rose(SEC_ENABLE) |-> (off_cnt >= MIN_OFF) && (off_cnt <= MAX_OFF))
        else $error("Switchover time out of range.");

    init_safe_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (state == ST_INIT && pri_fail) |=> !PRI_ENABLE && !SEC_ENABLE)
        else $error("Port enabled while primary still failed at start.");

    pri_fault_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (PRI_ENABLE && state == ST_PRI_ACTIVE && pri_fail) |=> !PRI_ENABLE ##1 !PRI_ENABLE)
        else $error("Primary kept after a fault.");

    resp_swap_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (SEC_ENABLE && full_mode && sec_flt[FLT_RESPONDER]) |=> !SEC_ENABLE)
        else $error("Responder indication ignored on secondary.");

    sticky_sec_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (SEC_ENABLE && !back_evt) |=> SEC_ENABLE)
        else $error("Secondary left without cause.");

    count_step_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (state != $past(state)) |-> (XFER_COUNT == $past(XFER_COUNT) + 1'b1))
        else $error("Transition not counted.");

    status_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        ##1 (PRI_LINK_UP == !$past(pri_fail)))
        else $error("Primary status does not follow its faults.");

    once_only_a: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
        (state == ST_PRI_ACTIVE && pri_fail) |=> (state == ST_TO_SEC) [*3])
        else $error("Fault acted on more than once.");

endmodule : link_failover_controller

`default_nettype wire

/* core/failover_pkg.sv */
// Constants shared by the paired redundant links failover controller.
package failover_pkg;

    // ==========================================================
    // Clock and timing
    // ==========================================================
    // Core clock period in nanoseconds (10 MHz).
    localparam int unsigned CLK_PERIOD_NS = 100;
    // Least gap between dropping one port and enabling the other, in ns.
    localparam int unsigned SWITCH_MIN_NS = 3_000_000;
    // Longest allowed switchover time, in ns.
    localparam int unsigned SWITCH_MAX_NS = 10_000_000;
    // Least gap in cycles, rounded up.
    localparam int unsigned SWITCH_MIN_CYCLES = (SWITCH_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest switchover in cycles, rounded down.
    localparam int unsigned SWITCH_MAX_CYCLES = SWITCH_MAX_NS / CLK_PERIOD_NS;
    // Width of the switchover timer.
    localparam int unsigned TIMER_W = 17;
    // Reset value of the switchover timer.
    localparam logic [TIMER_W-1:0] TIMER_RESET = 17'h00000;

    // ==========================================================
    // Transition counter
    // ==========================================================
    // Width of the link transition counter.
    localparam int unsigned COUNT_W = 16;
    // Reset value of the link transition counter.
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

    // ==========================================================
    // Per-link fault vector layout
    // ==========================================================
    // Receive link lost on the master port.
    localparam int unsigned FLT_RX_LOSS = 0;
    // Port partitioned.
    localparam int unsigned FLT_PARTITION = 1;
    // Excessive collision count.
    localparam int unsigned FLT_EXC_COLL = 2;
    // Over-long collision.
    localparam int unsigned FLT_LONG_COLL = 3;
    // Received jabber.
    localparam int unsigned FLT_JABBER = 4;
    // Attachment unit failure.
    localparam int unsigned FLT_MAU = 5;
    // Failure indication from a responder far end.
    localparam int unsigned FLT_RESPONDER = 6;
    // Width of a per-link fault vector.
    localparam int unsigned FLT_W = 7;

    // ==========================================================
    // Controller states
    // ==========================================================
    // Active-link controller states.
    typedef enum logic [2:0] {
        ST_INIT,
        ST_PRI_ACTIVE,
        ST_TO_SEC,
        ST_SEC_ACTIVE,
        ST_TO_PRI
    } link_state_t;

endpackage : failover_pkg

/* verification/remote_port_model.sv */
// Behavioural model of the far-end repeater ports on both redundant links.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Far-end ports, responder or nonresponder
// ==========================================================
module remote_port_model (
    input wire logic core_clk, // Shared core clock.
    input wire logic arst_n, // Asynchronous reset, active low.
    input wire logic responder, // High when the far ends can report back.
    input wire logic [1:0] rx_cut, // Far-end receive loss, bit 0 primary, bit 1 secondary.
    input wire logic [3:0] delay, // Cycles before a loss is reported.
    output logic [1:0] resp_fail, // Failure indications towards the master.
    output logic [1:0] port_enable // Far-end ports enabled.
);
    int unsigned wait_cnt [2]; // Cycles each loss has been seen so far.

    // The far ends never switch themselves off, so link choice stays with the master.
    assign port_enable = 2'b11;

    // A responder reports its own receive loss after a chosen delay, so both
    // prompt and slow far ends can be tried. A nonresponder has no way back.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < 2; i++) begin
                wait_cnt[i] = 0;
            end
            resp_fail <= 2'b00;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (rx_cut[i] && responder) begin
                    if (wait_cnt[i] >= delay) begin
                        resp_fail[i] <= 1'b1;
                    end else begin
                        wait_cnt[i]++;
                    end
                end else begin
                    // A healed link or a nonresponder drops the indication.
                    wait_cnt[i] = 0;
                    resp_fail[i] <= 1'b0;
                end
            end
        end
    end
endmodule : remote_port_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking testbench for the link failover controller.
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    import failover_pkg::*;
    // ==========================================================
    // Stimulus and observed signals
    // ==========================================================
    logic core_clk = 1'b0; // Core clock, 100 ns period.
    logic arst_n = 1'b0; // Reset, active low.
    logic full_detect = 1'b0; // Detection mode pin.
    logic [5:0] pri_flt = '0; // Primary local faults.
    logic [5:0] sec_flt = '0; // Secondary local faults.
    logic sec_disabled = 1'b0; // Secondary disabled internally.
    logic responder = 1'b0; // Far ends answer back.
    logic [1:0] rx_cut = 2'b00; // Far-end receive losses.
    logic [3:0] delay = 4'h0; // Far-end answer delay.
    logic [1:0] resp_fail; // Far-end indications.
    logic pri_en, sec_en, sec_use, pri_up, sec_up; // Controller outputs.
    logic [COUNT_W-1:0] xfer; // Transition count.
    int error_cnt = 0; // Mismatches seen.
    int check_count = 0; // Comparisons made.
    int exp_cnt = 0; // Reference model of the transition count.
    int n; // Cycles waited.

    // The clock toggles every half period.
    always #50 core_clk = ~core_clk;

    link_failover_controller uut (.CORE_CLK(core_clk), .ARST_N(arst_n),
        .FULL_DETECT(full_detect), .PRI_RX_LOSS(pri_flt[FLT_RX_LOSS]),
        .PRI_PARTITION(pri_flt[FLT_PARTITION]), .PRI_EXC_COLL(pri_flt[FLT_EXC_COLL]),
        .PRI_LONG_COLL(pri_flt[FLT_LONG_COLL]), .PRI_JABBER(pri_flt[FLT_JABBER]),
        .PRI_MAU_FAIL(pri_flt[FLT_MAU]), .PRI_RESP_FAIL(resp_fail[0]),
        .SEC_RX_LOSS(sec_flt[FLT_RX_LOSS]), .SEC_PARTITION(sec_flt[FLT_PARTITION]),
        .SEC_EXC_COLL(sec_flt[FLT_EXC_COLL]), .SEC_LONG_COLL(sec_flt[FLT_LONG_COLL]),
        .SEC_JABBER(sec_flt[FLT_JABBER]), .SEC_MAU_FAIL(sec_flt[FLT_MAU]),
        .SEC_RESP_FAIL(resp_fail[1]), .SEC_DISABLED(sec_disabled),
        .PRI_ENABLE(pri_en), .SEC_ENABLE(sec_en), .SEC_IN_USE(sec_use),
        .PRI_LINK_UP(pri_up), .SEC_LINK_UP(sec_up), .XFER_COUNT(xfer));

    remote_port_model far_end (.core_clk(core_clk), .arst_n(arst_n), .responder(responder),
        .rx_cut(rx_cut), .delay(delay), .resp_fail(resp_fail), .port_enable());

    // ==========================================================
    // Shared tasks
    // ==========================================================
    // Compares one value and reports a mismatch at once.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : chk

    // Lets k edges pass, then steps off the edge so outputs have settled.
    task automatic tick(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : tick

    // Waits, bounded, for one enable to reach a level; cnt gives the cycles taken.
    task automatic wait_en(input bit sec, input logic v, input int lim, output int cnt);
        cnt = 0;
        while ((sec ? sec_en : pri_en) !== v && cnt < lim) begin
            tick(1);
            cnt++;
        end
    endtask : wait_en

    // Resets for five cycles with the given mode and primary faults present.
    task automatic do_reset(input logic full, input logic [5:0] flt);
        @(posedge core_clk);
        arst_n <= 1'b0;
        pri_flt <= flt;
        sec_flt <= '0;
        sec_disabled <= 1'b0;
        rx_cut <= 2'b00;
        full_detect <= full;
        responder <= full;
        tick(2);
        chk(pri_en | sec_en | sec_use, 1'b0, "enables set in reset");
        chk(xfer, COUNT_RESET, "count not cleared");
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        exp_cnt = 1;
        for (int i = 0; i < 10; i++) begin
            tick(1);
            if (flt != '0) begin
                chk(pri_en, 1'b0, "faulty primary enabled at start");
            end
        end
        if (flt == '0) begin
            chk(pri_en, 1'b1, "primary not active after reset");
            chk(sec_en | sec_use, 1'b0, "secondary not on standby");
            chk(pri_up & sec_up, 1'b1, "link status wrong");
            chk(xfer, 16'(exp_cnt), "count after start");
        end
    endtask : do_reset

    // Expects the active port to drop within lim cycles, other port still off.
    task automatic expect_drop(input bit sec, input int lim);
        wait_en(sec, 1'b0, lim, n);
        chk(n < lim, 1'b1, "active port kept");
        chk(sec ? pri_en : sec_en, 1'b0, "other port enabled too early");
        chk(sec_use, !sec, "in-use flag wrong");
        exp_cnt++;
        chk(xfer, 16'(exp_cnt), "count at drop");
    endtask : expect_drop

    // Waits out the gap and checks its length against the allowed span.
    task automatic expect_rise(input bit sec);
        wait_en(sec, 1'b1, SWITCH_MAX_CYCLES, n);
        chk(n >= SWITCH_MIN_CYCLES && n < SWITCH_MAX_CYCLES, 1'b1, "gap length");
        chk(sec ? pri_en : sec_en, 1'b0, "both ports enabled");
        exp_cnt++;
        chk(xfer, 16'(exp_cnt), "count at enable");
    endtask : expect_rise

    // Prints the verdict and ends the run.
    task automatic report_and_stop;
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Both ports enabled at once would form a repeater loop.
    always @(negedge core_clk) begin
        check_count++;
        if (pri_en === 1'b1 && sec_en === 1'b1) begin
            error_cnt++;
            $display("unexpected at %0t: both ports enabled", $time);
        end
    end

    // Three full gaps take about 90,000 cycles; anything past 100,000 is a hang.
    initial begin
        repeat (100000) @(posedge core_clk);
        error_cnt++;
        report_and_stop();
    end

    // ==========================================================
    // Scenarios
    // ==========================================================
    initial begin
        void'($urandom(28));
        do_reset(1'b0, 6'h00);
        // A primary faulty from the start must not be enabled.
        do_reset(1'b0, 6'h01);
        chk(pri_en | pri_up, 1'b0, "faulty primary enabled");
        // Every partial-mode cause drops the primary; random secondary noise is ignored.
        for (int k = 0; k < 6; k++) begin
            do_reset(1'b0, 6'h00);
            @(posedge core_clk);
            sec_flt <= 6'($urandom);
            tick(6);
            chk(pri_en, 1'b1, "standby fault moved traffic");
            @(posedge core_clk);
            pri_flt[k] <= 1'b1;
            #1;
            expect_drop(1'b0, 8);
        end
        // In partial mode a responder indication is not honoured.
        do_reset(1'b0, 6'h00);
        @(posedge core_clk);
        responder <= 1'b1;
        rx_cut <= 2'b01;
        tick(20);
        chk(pri_en, 1'b1, "indication honoured in partial mode");
        // Full mode: a responder reports a loss on the primary transmit path.
        do_reset(1'b1, 6'h00);
        @(posedge core_clk);
        delay <= 4'($urandom_range(9));
        rx_cut <= 2'b01;
        #1;
        expect_drop(1'b0, 20);
        expect_rise(1'b1);
        // A repaired primary stays idle.
        @(posedge core_clk);
        rx_cut <= 2'b00;
        tick(50);
        chk(pri_en, 1'b0, "repaired primary came back");
        chk(pri_up & sec_use, 1'b1, "status after repair");
        // Disabling the secondary brings the primary back.
        @(posedge core_clk);
        sec_disabled <= 1'b1;
        #1;
        expect_drop(1'b1, 8);
        chk(sec_up, 1'b0, "disabled secondary shown healthy");
        expect_rise(1'b0);
        // A receive fault in full mode, then a slow responder on the secondary.
        @(posedge core_clk);
        sec_disabled <= 1'b0;
        pri_flt[FLT_RX_LOSS] <= 1'b1;
        #1;
        expect_drop(1'b0, 8);
        expect_rise(1'b1);
        @(posedge core_clk);
        pri_flt[FLT_RX_LOSS] <= 1'b0;
        delay <= 4'h9;
        rx_cut <= 2'b10;
        #1;
        expect_drop(1'b1, 20);
        report_and_stop();
    end
endmodule : tb_top
`default_nettype wire
